// ==== verilog/timer8_top.sv ====
/*
  eight-bit timer/counter with private prescaler, overflow flag and
  overflow gate pulse, reached over an APB slave.
  assumes external_clock_pin and sense_oscillator_clock are synchronous
  to pclk and that sleep_mode is a level from the power controller.
*/
// Local design decisions: the APB slave port and the placing of the registers.
// Functional notes
// - timer mode counts each instruction cycle
// - count write blocks increments two instruction cycles
// - counter mode counts selected input edges
// - source bit picks pin or sense oscillator
// - edge select applies to both sources
// - assign bit clear inserts prescaler, set bypasses
// - eight ratios one-to-two up to 256
// - prescaler is private to this timer
// - prescaler hidden, cleared on count write
// - overflow FF to 00 sets flag always
// - flag cleared only by software write
// - own overflow enable bit in interrupt control
// - counter edges sampled at phases two, four
// - sleep freezes timer and count
// - overflow offered as gate for other timer
module timer8_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_clock_pin,
  input  wire logic        sense_oscillator_clock,
  input  wire logic        sleep_mode,
  output logic             irq,
  output logic             overflow_gate
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  timer8_pkg::phase_type   phase_r;
  timer8_pkg::phase_type   phase_nxt;
  timer8_pkg::reg_sel_type sel;

  logic [7:0]  count_r;
  logic [5:0]  option_r;
  logic        ext_sel_r;
  logic        ie_r;
  logic        flag_r;
  logic [1:0]  inhibit_r;
  logic        src_prev_r;
  logic        samp_r;
  logic        gate_r;
  logic [31:0] prdata_r;

  logic        setup;
  logic        access;
  logic        wr_en;
  logic        cnt_wr;
  logic        flag_clr;
  logic        ph2_en;
  logic        ph4_en;
  logic        samp_en;
  logic        cs;
  logic        bypass;
  logic [2:0]  rate;
  logic        src_raw;
  logic        src_lvl;
  logic        presc_tick;
  logic        presc_out;
  logic [7:0]  presc_cnt;
  logic        p_lvl;
  logic        inc_req;
  logic        inc;
  logic        ovf;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic timer8_pkg::reg_sel_type reg_decode(input logic [7:0] a);
    if (a == timer8_pkg::ADDR_COUNT) begin
      return timer8_pkg::SEL_COUNT;
    end else if (a == timer8_pkg::ADDR_OPTION) begin
      return timer8_pkg::SEL_OPTION;
    end else if (a == timer8_pkg::ADDR_SRC) begin
      return timer8_pkg::SEL_SRC;
    end else if (a == timer8_pkg::ADDR_INTCTL) begin
      return timer8_pkg::SEL_INTCTL;
    end else if (a == timer8_pkg::ADDR_STATUS) begin
      return timer8_pkg::SEL_STATUS;
    end else if (a == timer8_pkg::ADDR_MASK) begin
      return timer8_pkg::SEL_MASK;
    end else begin
      return timer8_pkg::SEL_NONE;
    end
  endfunction : reg_decode

  assign sel     = reg_decode(paddr);
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign wr_en   = access && pwrite && (sel != timer8_pkg::SEL_NONE);
  assign cnt_wr  = wr_en && (sel == timer8_pkg::SEL_COUNT);
  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = access && (sel == timer8_pkg::SEL_NONE);
  assign prdata  = prdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // read data is latched in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_r <= 32'h0000_0000;
      if (sel == timer8_pkg::SEL_COUNT) begin
        prdata_r[7:0] <= count_r;
      end else if (sel == timer8_pkg::SEL_OPTION) begin
        prdata_r[5:0] <= option_r;
      end else if (sel == timer8_pkg::SEL_SRC) begin
        prdata_r[timer8_pkg::SRC_XS_BIT] <= ext_sel_r;
      end else if (sel == timer8_pkg::SEL_INTCTL) begin
        prdata_r[timer8_pkg::ICTL_IE_BIT] <= ie_r;
        prdata_r[timer8_pkg::ICTL_IF_BIT] <= flag_r;
      end else if (sel == timer8_pkg::SEL_STATUS) begin
        prdata_r[timer8_pkg::IRQ_OVF_BIT] <= flag_r;
      end else if (sel == timer8_pkg::SEL_MASK) begin
        prdata_r[timer8_pkg::IRQ_OVF_BIT] <= ie_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_r <= timer8_pkg::OPTION_RST;
    end else if (wr_en && (sel == timer8_pkg::SEL_OPTION)) begin
      option_r <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sel_r <= timer8_pkg::XS_RST;
    end else if (wr_en && (sel == timer8_pkg::SEL_SRC)) begin
      ext_sel_r <= pwdata[timer8_pkg::SRC_XS_BIT];
    end
  end

  // one enable bit, visible both in interrupt control and in the mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_r <= timer8_pkg::IE_RST;
    end else if (wr_en && (sel == timer8_pkg::SEL_INTCTL)) begin
      ie_r <= pwdata[timer8_pkg::ICTL_IE_BIT];
    end else if (wr_en && (sel == timer8_pkg::SEL_MASK)) begin
      ie_r <= pwdata[timer8_pkg::IRQ_OVF_BIT];
    end
  end

  assign cs   = option_r[timer8_pkg::OPT_CS_BIT];
  assign bypass = option_r[timer8_pkg::OPT_BP_BIT];
  assign rate   = option_r[timer8_pkg::OPT_RT_LSB +: timer8_pkg::OPT_RT_W];

  ////////////////////////////////////////////////////////////////////////////
  // instruction clock phases; frozen in sleep so nothing advances
  always_comb begin
    case (phase_r)
      timer8_pkg::PH_1: phase_nxt = timer8_pkg::PH_2;
      timer8_pkg::PH_2: phase_nxt = timer8_pkg::PH_3;
      timer8_pkg::PH_3: phase_nxt = timer8_pkg::PH_4;
      default:          phase_nxt = timer8_pkg::PH_1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= timer8_pkg::PH_1;
    end else if (!sleep_mode) begin
      phase_r <= phase_nxt;
    end
  end

  assign ph2_en  = !sleep_mode && (phase_r == timer8_pkg::PH_2);
  assign ph4_en  = !sleep_mode && (phase_r == timer8_pkg::PH_4);
  assign samp_en = ph2_en || ph4_en;

  ////////////////////////////////////////////////////////////////////////////
  // source select and edge polarity
  assign src_raw = ext_sel_r ? sense_oscillator_clock : external_clock_pin;
  // inverting the level turns falling edges into rising ones
  assign src_lvl = src_raw ^ option_r[timer8_pkg::OPT_SE_BIT];

  // reset to the level an idle low input shows, so no false edge follows reset;
  // flipping the edge bit on a steady input still counts once: rewrite the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_r <= timer8_pkg::OPTION_RST[timer8_pkg::OPT_SE_BIT];
    end else begin
      src_prev_r <= src_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // private prescaler, never shared with the watchdog
  assign presc_tick = !sleep_mode && (cs ? (src_lvl && !src_prev_r) : ph4_en);

  timer8_prescaler #(
    .WIDTH (8)
  ) u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (presc_tick),
    .clr     (cnt_wr),
    .rate    (rate),
    .count   (presc_cnt),
    .out     (presc_out)
  );

  assign p_lvl = bypass ? src_lvl : presc_out;

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser: the divided level is looked at only on phases two and four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_r <= timer8_pkg::OPTION_RST[timer8_pkg::OPT_SE_BIT];
    end else if (samp_en) begin
      samp_r <= p_lvl;
    end
  end

  // timer mode without prescaler needs no edge detect: one per instruction cycle
  assign inc_req = (!cs && bypass) ? ph4_en : (samp_en && p_lvl && !samp_r);
  assign inc     = inc_req && (inhibit_r == 2'h0) && !cnt_wr;
  assign ovf     = inc && (count_r == timer8_pkg::COUNT_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // write inhibit, counted in instruction cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_r <= 2'h0;
    end else if (cnt_wr) begin
      inhibit_r <= timer8_pkg::INHIBIT_LOAD;
    end else if (ph4_en && (inhibit_r != 2'h0)) begin
      inhibit_r <= inhibit_r - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count register; a software write wins over an increment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= timer8_pkg::COUNT_RST;
    end else if (cnt_wr) begin
      count_r <= pwdata[7:0];
    end else if (inc) begin
      count_r <= count_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow flag: set wins over a clear in the same cycle
  assign flag_clr = wr_en &&
                    (((sel == timer8_pkg::SEL_STATUS) && pwdata[timer8_pkg::IRQ_OVF_BIT]) ||
                     ((sel == timer8_pkg::SEL_INTCTL) && pwdata[timer8_pkg::ICTL_IF_BIT]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= timer8_pkg::FLAG_RST;
    end else if (ovf) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_r <= 1'b0;
    end else begin
      gate_r <= ovf;
    end
  end

  assign overflow_gate = gate_r;
  assign irq           = flag_r && ie_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_timer_rate;
    (!cs && bypass && ph4_en && (inhibit_r == 2'h0) && !cnt_wr)
      |=> (count_r == $past(count_r) + 8'h01);
  endproperty
  a_timer_rate : assert property (p_timer_rate) else $error("timer mode missed an increment");

  property p_write_inhibit;
    cnt_wr |=> ($stable(count_r) || $past(cnt_wr)) [*7];
  endproperty
  a_write_inhibit : assert property (p_write_inhibit) else $error("count moved right after a write");

  property p_presc_clear;
    cnt_wr |=> (presc_cnt == 8'h00);
  endproperty
  a_presc_clear : assert property (p_presc_clear) else $error("prescaler not cleared by count write");

  property p_overflow_flag;
    (inc && (count_r == 8'hFF)) |=> (flag_r && (count_r == 8'h00));
  endproperty
  a_overflow_flag : assert property (p_overflow_flag) else $error("wrap did not set the flag");

  property p_flag_sticky;
    (flag_r && !flag_clr) |=> flag_r;
  endproperty
  a_flag_sticky : assert property (p_flag_sticky) else $error("flag dropped without software clear");

  property p_sync_phase;
    (cs && inc) |-> (ph2_en || ph4_en);
  endproperty
  a_sync_phase : assert property (p_sync_phase) else $error("counter edge taken off the sample phases");

  property p_sleep_freeze;
    (sleep_mode && !cnt_wr) |=> $stable(count_r);
  endproperty
  a_sleep_freeze : assert property (p_sleep_freeze) else $error("count moved during sleep");

  property p_gate_pulse;
    ovf |=> overflow_gate ##1 !overflow_gate;
  endproperty
  a_gate_pulse : assert property (p_gate_pulse) else $error("gate pulse missing after overflow");

  property p_irq_level;
    $rose(flag_r) |-> (irq == ie_r);
  endproperty
  a_irq_level : assert property (p_irq_level) else $error("irq does not follow flag and enable");

  property p_presc_ratio;
    (presc_tick && !cnt_wr) |=> ((presc_cnt == $past(presc_cnt) + 8'h01) && (presc_out == presc_cnt[rate]));
  endproperty
  a_presc_ratio : assert property (p_presc_ratio) else $error("prescaler tap wrong");

  property p_cov_overflow;
    ovf ##1 irq;
  endproperty
  c_cov_overflow : cover property (p_cov_overflow);

  property p_cov_counter;
    cs && inc;
  endproperty
  c_cov_counter : cover property (p_cov_counter);

  property p_cov_inhibit;
    cnt_wr ##[1:20] inc;
  endproperty
  c_cov_inhibit : cover property (p_cov_inhibit);

endmodule : timer8_top

// ==== verilog/timer8_pkg.sv ====
/*
  shared constants of the eight-bit timer: register map, field positions,
  reset values, clock phases and instruction-cycle timing.
  assumes one 40 MHz pclk; an instruction cycle is four pclk phases.
*/
package timer8_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS    = 25;
  localparam int INSTR_CYCLE_NS   = 100;
  localparam int PHASES_PER_INSTR = INSTR_CYCLE_NS / CLK_PERIOD_NS;
  localparam int INHIBIT_INSTR    = 2;
  localparam logic [1:0] INHIBIT_LOAD = 2'(INHIBIT_INSTR);

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [7:0] ADDR_COUNT  = 8'h00;
  localparam logic [7:0] ADDR_OPTION = 8'h04;
  localparam logic [7:0] ADDR_SRC    = 8'h08;
  localparam logic [7:0] ADDR_INTCTL = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int OPT_CS_BIT  = 5;
  localparam int OPT_SE_BIT  = 4;
  localparam int OPT_BP_BIT  = 3;
  localparam int OPT_RT_LSB  = 0;
  localparam int OPT_RT_W    = 3;
  localparam int SRC_XS_BIT  = 0;
  localparam int ICTL_IE_BIT = 5;
  localparam int ICTL_IF_BIT = 2;
  localparam int IRQ_OVF_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [5:0] OPTION_RST = 6'h3F;
  localparam logic       XS_RST     = 1'h0;
  localparam logic       IE_RST     = 1'h0;
  localparam logic       FLAG_RST   = 1'h0;
  localparam logic [7:0] COUNT_MAX  = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    PH_1 = 2'b00,
    PH_2 = 2'b01,
    PH_3 = 2'b10,
    PH_4 = 2'b11
  } phase_type;

  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_COUNT  = 3'b001,
    SEL_OPTION = 3'b010,
    SEL_SRC    = 3'b011,
    SEL_INTCTL = 3'b100,
    SEL_STATUS = 3'b101,
    SEL_MASK   = 3'b110
  } reg_sel_type;

endpackage : timer8_pkg

// ==== verilog/timer8_prescaler.sv ====
/*
  programmable power-of-two prescaler private to the eight-bit timer.
  assumes tick is a one-pclk pulse and clr a one-pclk pulse from a count write.
*/
module timer8_prescaler #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             tick,
  input  wire logic             clr,
  input  wire logic [2:0]       rate,
  output logic      [WIDTH-1:0] count,
  output logic                  out
);

  logic [WIDTH-1:0] count_r;

  ////////////////////////////////////////////////////////////////////////////
  // software reaches count_r only through the clear of a count write; otherwise only the tick moves it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else if (clr) begin
      count_r <= '0;
    end else if (tick) begin
      count_r <= count_r + WIDTH'(1);
    end
  end

  // bit n has a period of 2^(n+1) ticks, so its rise divides by 2..256
  assign out   = count_r[rate];
  assign count = count_r;

endmodule : timer8_prescaler

// ==== tb/edge_source.sv ====
/*
  model of the counter inputs: the external clock pin and the sensing
  oscillator. each line holds its own level and idles low.
  assumes one pclk domain and a request pulse of one cycle.
*/
module edge_source #(
  parameter int HALF = 4
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic       sel,
  input  wire logic [4:0] toggles,
  output logic            busy,
  output logic            external_clock_pin,
  output logic            sense_oscillator_clock
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [4:0] left_r;
  logic [3:0] hold_r;
  logic       sel_r;
  logic       pin_r;
  logic       osc_r;

  ////////////////////////////////////////////////////////////////////////////
  // a level lasts a full instruction cycle, so both samples of a cycle see it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r <= 5'h00;
      hold_r <= 4'h0;
      sel_r  <= 1'b0;
      pin_r  <= 1'b0;
      osc_r  <= 1'b0;
    end else if (go && left_r == 5'h00) begin
      left_r <= toggles;
      sel_r  <= sel;
      hold_r <= 4'(HALF - 1);
    end else if (left_r != 5'h00) begin
      if (hold_r == 4'h0) begin
        if (sel_r) begin
          osc_r <= ~osc_r;
        end else begin
          pin_r <= ~pin_r;
        end
        left_r <= left_r - 5'h01;
        hold_r <= 4'(HALF - 1);
      end else begin
        hold_r <= hold_r - 4'h1;
      end
    end
  end

  assign busy                   = (left_r != 5'h00);
  assign external_clock_pin     = pin_r;
  assign sense_oscillator_clock = osc_r;
endmodule : edge_source

// ==== tb/tb.sv ====
/*
  self-checking bench of the eight-bit timer: apb register tasks, count
  rate measurements, overflow flag and interrupt, counter inputs, sleep.
  assumes the zero-wait apb slave and the register map of timer8_pkg.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] A_CNT = timer8_pkg::ADDR_COUNT;
  localparam logic [7:0] A_OPT = timer8_pkg::ADDR_OPTION;
  localparam logic [7:0] A_ICT = timer8_pkg::ADDR_INTCTL;
  localparam logic [7:0] A_STA = timer8_pkg::ADDR_STATUS;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        osc;
  logic        sleep_mode;
  logic        irq;
  logic        overflow_gate;
  logic        go;
  logic        sel;
  logic [4:0]  toggles;
  logic        busy;
  logic        last_err;
  logic [31:0] gate_cnt = 32'h0;
  int          error_cnt = 0;
  int          compares = 0;

  timer8_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_clock_pin(pin), .sense_oscillator_clock(osc), .sleep_mode(sleep_mode), .irq(irq),
    .overflow_gate(overflow_gate));

  edge_source u_src (.pclk(pclk), .presetn(presetn), .go(go), .sel(sel), .toggles(toggles), .busy(busy),
    .external_clock_pin(pin), .sense_oscillator_clock(osc));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (overflow_gate === 1'b1) begin
      gate_cnt <= gate_cnt + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    apb(a, 1'b1, d, v);
  endtask : wr

  // the span from a count write to the read latch is gap+2 edges
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input int gap = 0);
    logic [31:0] v;
    repeat (gap) @(posedge pclk);
    apb(a, 1'b0, 32'h0, v);
    check(v, exp);
  endtask : rd_chk

  // two count reads whose latch edges lie span cycles apart
  task automatic rate_chk(input int span, input logic [7:0] exp);
    logic [31:0] c1;
    logic [31:0] c2;
    apb(A_CNT, 1'b0, 32'h0, c1);
    repeat (span - 3) @(posedge pclk);
    apb(A_CNT, 1'b0, 32'h0, c2);
    check({24'h0, c2[7:0] - c1[7:0]}, {24'h0, exp});
  endtask : rate_chk

  task automatic pulse(input logic s, input logic [4:0] k);
    int n;
    n = 0;
    @(posedge pclk);
    go      <= 1'b1;
    sel     <= s;
    toggles <= k;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy === 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500) error_cnt++;
    repeat (8) @(posedge pclk);
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #600000;
    error_cnt++;
    conclude();
  end

  initial begin
    logic [31:0] v1;
    logic [31:0] v2;
    {psel, penable, pwrite, paddr, pwdata, sleep_mode, go, sel, toggles} = '0;
    last_err = 1'b0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(A_CNT, 32'h00);
    rd_chk(A_CNT, 32'h00, 20);
    rd_chk(A_OPT, 32'h3F);
    rd_chk(timer8_pkg::ADDR_SRC, 32'h0);
    rd_chk(A_ICT, 32'h00);
    rd_chk(A_STA, 32'h0);
    rd_chk(timer8_pkg::ADDR_MASK, 32'h0);
    rd_chk(8'h18, 32'h0);
    check({31'h0, last_err}, 32'h1);
    wr(A_OPT, 32'hFF);
    rd_chk(A_OPT, 32'h3F);
    // timer mode: one step per four pclk bypassed, write inhibit, then all eight prescaler ratios
    wr(A_OPT, 32'h08);
    rate_chk(400, 8'd100);
    wr(A_CNT, 32'h40);
    rd_chk(A_CNT, 32'h43, 19);
    for (int n = 0; n < 8; n++) begin
      wr(A_OPT, 32'(n));
      wr(A_CNT, 32'h0);
      repeat (12) @(posedge pclk);
      rate_chk(16 << n, 8'h02);
    end
    // overflow, flag, enable and interrupt
    wr(A_OPT, 32'h08);
    wr(A_CNT, 32'hFE);
    rd_chk(A_CNT, 32'h00, 15);
    rd_chk(A_STA, 32'h1);
    rd_chk(A_ICT, 32'h04);
    check({31'h0, irq}, 32'h0);
    check(gate_cnt, 32'h1);
    wr(timer8_pkg::ADDR_MASK, 32'h1);
    rd_chk(A_ICT, 32'h24);
    check({31'h0, irq}, 32'h1);
    wr(A_ICT, 32'h20);
    rd_chk(A_ICT, 32'h24, 20);
    wr(A_ICT, 32'h24);
    rd_chk(A_ICT, 32'h20);
    check({31'h0, irq}, 32'h0);
    wr(A_CNT, 32'hFF);
    rd_chk(A_CNT, 32'h00, 11);
    check({31'h0, irq}, 32'h1);
    wr(A_STA, 32'h1);
    rd_chk(A_STA, 32'h0);
    check(gate_cnt, 32'h2);
    wr(timer8_pkg::ADDR_MASK, 32'h0);
    // counter mode: both sources, both edges, the other source busy too
    for (int i = 0; i < 4; i++) begin
      wr(A_OPT, i[0] ? 32'h38 : 32'h28);
      wr(timer8_pkg::ADDR_SRC, {31'h0, i[1]});
      wr(A_CNT, 32'h0);
      repeat (12) @(posedge pclk);
      pulse(!i[1], 5'd6);
      pulse(i[1], 5'd5);
      rd_chk(A_CNT, i[0] ? 32'h2 : 32'h3);
      pulse(i[1], 5'd1);
    end
    // sleep freezes the count
    wr(A_OPT, 32'h08);
    @(posedge pclk);
    sleep_mode <= 1'b1;
    apb(A_CNT, 1'b0, 32'h0, v1);
    repeat (40) @(posedge pclk);
    apb(A_CNT, 1'b0, 32'h0, v2);
    check(v2, v1);
    sleep_mode <= 1'b0;
    rate_chk(40, 8'd10);
    conclude();
  end
endmodule : tb
